/* File: rtl/timer_pkg.sv */
// constants, register map and types of the multimode timer channel
package timer_pkg;
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  localparam int          PRESCALE_W      = 8;
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_COUNT       = 4'h4;
  localparam logic [3:0]  REG_IRQ         = 4'h8;
  localparam logic [3:0]  REG_PRESCALE    = 4'hC;
  localparam int          CTRL_START_BIT  = 0;
  localparam int          CTRL_MODE_LSB   = 1;
  localparam int          CTRL_UP_BIT     = 3;
  localparam int          CTRL_FREE_BIT   = 4;
  localparam int          CTRL_TRIG_BIT   = 5;
  localparam int          CTRL_EDGE_BIT   = 6;
  localparam int          IRQ_FLAG_BIT    = 0;
  localparam int          IRQ_PIN_BIT     = 1;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] RELOAD_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES  = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;
  localparam logic [7:0]  PRESCALE_RESET  = 8'h00;

  typedef enum logic [1:0] {
    mode_timer,
    mode_event,
    mode_oneshot,
    mode_pwm
  } mode_type;

  typedef enum logic [1:0] {
    st_idle,
    st_wait,
    st_high,
    st_low
  } run_type;
endpackage : timer_pkg

/* File: rtl/tick_link.sv */
// carrier between the channel core and its tick and edge generator
interface tick_link;
  import timer_pkg::*;
  logic [PRESCALE_W-1:0] prescale;
  logic                  edge_sel;
  logic                  tick;
  logic                  pin_edge;
  modport gen  (input prescale, input edge_sel, output tick, output pin_edge);
  modport user (output prescale, output edge_sel, input tick, input pin_edge);
endinterface : tick_link

/* File: rtl/tick_gen.sv */
// count clock divider and event pin edge detector
module tick_gen
  import timer_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic event_pin_i,
  tick_link.gen     lnk
);
  logic [PRESCALE_W-1:0] div;
  logic                  pin_prev;

  // one-cycle enable every prescale+1 clocks
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= PRESCALE_RESET;
    end else if (div >= lnk.prescale) begin
      div <= PRESCALE_RESET;
    end else begin
      div <= div + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= event_pin_i;
    end
  end

  assign lnk.tick     = (div >= lnk.prescale);
  assign lnk.pin_edge = lnk.edge_sel ? (pin_prev & ~event_pin_i) : (~pin_prev & event_pin_i);
endmodule : tick_gen

/* File: rtl/multimode_timer_counter.sv */
// sixteen-bit multimode timer channel with register port and pulse output
module multimode_timer_counter
  import timer_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              timer_event_input_pin_i,
  output logic                   timer_pulse_output_pin_o,
  output logic                   irq_request_o
);
  tick_link lnk ();

  logic                  start;
  mode_type              mode;
  logic                  count_up;
  logic                  free_run;
  logic                  trig_en;
  logic                  edge_sel;
  logic [PRESCALE_W-1:0] prescale;
  logic [15:0]           count;
  logic [15:0]           reload;
  run_type               state;
  logic                  irq;
  logic                  pin;

  logic     wr_ctrl;
  logic     wr_count;
  logic     wr_irq;
  logic     wr_pre;
  logic     rd_count;
  mode_type new_mode;
  logic     new_start;
  logic     stop_req;
  logic     os_stop;
  logic     pwm_stop;
  logic     mode_enter;
  logic     trigger;
  logic     cnt_en;
  logic     up_dir;
  logic     at_end;
  logic     underflow;
  logic     overflow;
  logic     wrap_tev;
  logic     irq_set;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  tick_gen u_tick (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .event_pin_i (timer_event_input_pin_i),
    .lnk         (lnk)
  );

  assign lnk.prescale = prescale;
  assign lnk.edge_sel = edge_sel;

  // bus decode
  assign wr_ctrl   = wr_i && (addr_i == REG_CTRL);
  assign wr_count  = wr_i && (addr_i == REG_COUNT);
  assign wr_irq    = wr_i && (addr_i == REG_IRQ);
  assign wr_pre    = wr_i && (addr_i == REG_PRESCALE);
  assign rd_count  = rd_i && (addr_i == REG_COUNT);
  assign new_mode  = mode_type'(wdata_i[CTRL_MODE_LSB +: 2]);
  assign new_start = wdata_i[CTRL_START_BIT];

  // stop and mode-change events
  assign stop_req   = wr_ctrl && start && !new_start;
  assign os_stop    = stop_req && (mode == mode_oneshot) && (state == st_high);
  assign pwm_stop   = stop_req && (mode == mode_pwm);
  assign mode_enter = wr_ctrl && ((mode == mode_timer) || (mode == mode_event)) &&
                      ((new_mode == mode_oneshot) || (new_mode == mode_pwm));

  // counting conditions
  assign trigger = trig_en ? lnk.pin_edge : 1'b1;
  assign up_dir  = (mode == mode_event) && count_up;
  always_comb begin
    cnt_en = 1'b0;
    if (start) begin
      case (mode)
        mode_timer:   cnt_en = lnk.tick;
        mode_event:   cnt_en = lnk.pin_edge;
        mode_oneshot: cnt_en = lnk.tick && (state == st_high);
        mode_pwm:     cnt_en = lnk.tick && ((state == st_high) || (state == st_low));
        default:      cnt_en = 1'b0;
      endcase
    end
  end
  assign at_end    = up_dir ? (count == COUNT_ALL_ONES) : (count == COUNT_ZERO);
  assign underflow = cnt_en && !up_dir && (count == COUNT_ZERO);
  assign overflow  = cnt_en && up_dir && (count == COUNT_ALL_ONES);
  assign wrap_tev  = (underflow || overflow) && ((mode == mode_timer) || (mode == mode_event));

  // control register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start    <= 1'b0;
      mode     <= mode_timer;
      count_up <= 1'b0;
      free_run <= 1'b0;
      trig_en  <= 1'b0;
      edge_sel <= 1'b0;
    end else if (wr_ctrl) begin
      start    <= new_start;
      mode     <= new_mode;
      count_up <= wdata_i[CTRL_UP_BIT];
      free_run <= wdata_i[CTRL_FREE_BIT];
      trig_en  <= wdata_i[CTRL_TRIG_BIT];
      edge_sel <= wdata_i[CTRL_EDGE_BIT];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prescale <= PRESCALE_RESET;
    end else if (wr_pre) begin
      prescale <= wdata_i[PRESCALE_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reload <= RELOAD_RESET;
    end else if (wr_count) begin
      reload <= wdata_i;
    end
  end

  // one-shot and pwm sequencing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= st_idle;
    end else if (wr_ctrl) begin
      state <= (new_start && (new_mode == mode_oneshot || new_mode == mode_pwm)) &&
               (state != st_idle) && (new_mode == mode) ? state :
               (new_start ? st_wait : st_idle);
    end else begin
      case (state)
        st_idle: state <= st_idle;
        st_wait: begin
          if (trigger && (mode == mode_oneshot || mode == mode_pwm)) begin
            state <= st_high;
          end
        end
        st_high: begin
          if (underflow) begin
            state <= (mode == mode_pwm) ? st_low : st_wait;
          end
        end
        st_low: begin
          if (underflow) begin
            state <= st_high;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // counter
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= COUNT_RESET;
    end else if (wr_count && !start) begin
      count <= wdata_i;
    end else if (os_stop) begin
      count <= reload;
    end else if (state == st_wait && trigger && mode == mode_pwm && !wr_ctrl) begin
      count <= reload;
    end else if (cnt_en) begin
      if (at_end && !(free_run && mode == mode_event)) begin
        if (mode == mode_pwm && state == st_high) begin
          count <= ~reload;
        end else begin
          count <= reload;
        end
      end else if (up_dir) begin
        count <= count + 16'h0001;
      end else begin
        count <= count - 16'h0001;
      end
    end
  end

  // pulse output pin
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin <= 1'b0;
    end else if (os_stop || pwm_stop) begin
      pin <= 1'b0;
    end else if (wr_ctrl) begin
      pin <= pin && new_start && (new_mode == mode);
    end else if (state == st_wait && trigger && (mode == mode_oneshot || mode == mode_pwm)) begin
      pin <= 1'b1;
    end else if (underflow && state == st_high) begin
      pin <= 1'b0;
    end else if (underflow && state == st_low) begin
      pin <= 1'b1;
    end
  end

  // interrupt request flag, a hardware set beats a software clear
  assign irq_set = os_stop ||
                   (pwm_stop && pin) ||
                   mode_enter ||
                   (underflow || overflow) && !wr_ctrl &&
                   (mode != mode_pwm || state == st_high);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq <= 1'b0;
    end else if (irq_set) begin
      irq <= 1'b1;
    end else if (wr_irq) begin
      irq <= wdata_i[IRQ_FLAG_BIT];
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= COUNT_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        REG_CTRL:     rdata_o <= {9'h000, edge_sel, trig_en, free_run, count_up, mode, start};
        REG_COUNT: begin
          if (wrap_tev) begin
            rdata_o <= underflow ? COUNT_ALL_ONES : COUNT_ZERO;
          end else begin
            rdata_o <= count;
          end
        end
        REG_IRQ:      rdata_o <= {14'h0000, pin, irq};
        REG_PRESCALE: rdata_o <= {8'h00, prescale};
        default:      rdata_o <= COUNT_ZERO;
      endcase
    end else begin
      rdata_o <= COUNT_ZERO;
    end
  end

  assign timer_pulse_output_pin_o = pin;
  assign irq_request_o            = irq;

  // a read returns the sampled count and only counting or a pwm start load moves it
  property p_read_live;
    rd_count && !wrap_tev |=> rdata_o == $past(count) &&
                              (count == $past(count) || $past(cnt_en) ||
                               $past(state) == st_wait);
  endproperty
  a_read_live: assert property (p_read_live) else $error("count read not live");

  property p_read_reload_timer;
    rd_count && underflow && mode == mode_timer |=> rdata_o == 16'hFFFF;
  endproperty
  a_read_reload_timer: assert property (p_read_reload_timer)
    else $error("timer reload read not all ones");

  property p_read_overflow;
    rd_count && overflow && mode == mode_event |=> rdata_o == 16'h0000;
  endproperty
  a_read_overflow: assert property (p_read_overflow)
    else $error("overflow reload read not zero");

  property p_read_underflow_event;
    rd_count && underflow && mode == mode_event |=> rdata_o == COUNT_ALL_ONES;
  endproperty
  a_read_underflow_event: assert property (p_read_underflow_event)
    else $error("event underflow read not all ones");

  property p_write_halted;
    (wr_count && !start) ##1 (rd_count && !start) |=> rdata_o == $past(count) &&
                                                     $past(count) == $past(wdata_i, 2);
  endproperty
  a_write_halted: assert property (p_write_halted)
    else $error("halted write not read back");

  property p_os_stop_reload;
    os_stop |=> count == $past(reload) && state == st_idle && !start;
  endproperty
  a_os_stop_reload: assert property (p_os_stop_reload)
    else $error("one-shot stop did not reload");

  property p_os_stop_halts;
    os_stop ##1 !wr_count |=> $stable(count);
  endproperty
  a_os_stop_halts: assert property (p_os_stop_halts)
    else $error("one-shot stop did not halt");

  property p_os_stop_pin;
    os_stop |=> (!timer_pulse_output_pin_o) [*2];
  endproperty
  a_os_stop_pin: assert property (p_os_stop_pin) else $error("one-shot stop pin not low");

  property p_os_stop_irq;
    os_stop |=> irq_request_o;
  endproperty
  a_os_stop_irq: assert property (p_os_stop_irq) else $error("one-shot stop flag not set");

  property p_mode_enter;
    mode_enter |=> irq_request_o && (mode == mode_oneshot || mode == mode_pwm);
  endproperty
  a_mode_enter: assert property (p_mode_enter)
    else $error("mode entry flag not set");

  property p_pwm_stop_high;
    pwm_stop && pin |=> !timer_pulse_output_pin_o && irq_request_o;
  endproperty
  a_pwm_stop_high: assert property (p_pwm_stop_high)
    else $error("pwm stop from high wrong");

  property p_pwm_stop_low;
    pwm_stop && !pin |=> !timer_pulse_output_pin_o && irq_request_o == $past(irq);
  endproperty
  a_pwm_stop_low: assert property (p_pwm_stop_low) else $error("pwm stop from low wrong");

  property p_timer_reload;
    underflow && mode == mode_timer && !wr_ctrl && !wr_count |=>
      count == $past(reload) && irq_request_o;
  endproperty
  a_timer_reload: assert property (p_timer_reload) else $error("timer reload missing");

  // a software clear in the same cycle must not swallow a hardware set
  property p_irq_set_wins;
    irq_set |=> irq_request_o;
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins)
    else $error("request flag set lost");

  c_oneshot_done: cover property (state == st_high && underflow && mode == mode_oneshot);
  c_pwm_cycle:    cover property (state == st_low ##[1:300] state == st_high);
  c_overflow:     cover property (overflow && mode == mode_event);
  c_os_stop:      cover property (os_stop);
  c_free_wrap:    cover property (overflow && free_run && mode == mode_event);
endmodule : multimode_timer_counter

/* File: verification/tb_multimode_timer_counter.sv */
// self-checking bench of the multimode timer channel through its register port
module tb_multimode_timer_counter;
  timeunit 1ns;
  timeprecision 100ps;
  import timer_pkg::*;

  logic              core_clk_i;
  logic              rst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic              ev_pin;
  logic              pulse_pin;
  logic              irq;
  logic              toggle_en;
  int                fail_count;
  int                n_compared;
  logic              hit;

  multimode_timer_counter multimode_timer_counter_inst (
    .core_clk_i              (core_clk_i),
    .rst_i                   (rst_i),
    .addr_i                  (addr_i),
    .wdata_i                 (wdata_i),
    .wr_i                    (wr_i),
    .rd_i                    (rd_i),
    .rdata_o                 (rdata_o),
    .timer_event_input_pin_i (ev_pin),
    .timer_pulse_output_pin_o(pulse_pin),
    .irq_request_o           (irq)
  );

  always #2 core_clk_i = ~core_clk_i;

  // event source: one rising edge every two clocks
  always @(posedge core_clk_i) begin
    if (toggle_en) begin
      ev_pin <= ~ev_pin;
    end
  end

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd_reg

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd_reg(a, d);
    check(name, d, exp);
  endtask : rd_chk

  // back-to-back counter reads; every value must be within lo..hi or the marker
  task automatic burst(input int n, input logic [15:0] lo, input logic [15:0] hi,
                       input logic [15:0] mark, output logic seen_mark);
    logic [15:0] v;
    seen_mark = 1'b0;
    @(posedge core_clk_i);
    addr_i <= REG_COUNT;
    rd_i   <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      if (i == n - 1) begin
        rd_i <= 1'b0;
      end
      #1 v = rdata_o;
      if (v === mark) begin
        seen_mark = 1'b1;
      end
      check("count_in_range", {15'h0, ((v >= lo && v <= hi) === 1'b1) || v === mark},
            16'h0001);
    end
  endtask : burst

  task automatic wait_pin(input logic val, input int bound);
    int k;
    k = 0;
    #1;
    while (pulse_pin !== val && k < bound) begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    if (pulse_pin !== val) begin
      check("pin_wait", {15'h0, pulse_pin}, {15'h0, val});
      report_and_stop();
    end
  endtask : wait_pin

  task automatic settle;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : settle

  initial begin
    core_clk_i = 1'b0;
    rst_i      = 1'b1;
    addr_i     = '0;
    wdata_i    = '0;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    ev_pin     = 1'b0;
    toggle_en  = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped place
    rd_chk("ctrl", REG_CTRL, 16'h0000);
    rd_chk("count", REG_COUNT, COUNT_RESET);
    rd_chk("irq_reg", REG_IRQ, 16'h0000);
    rd_chk("prescale", REG_PRESCALE, {8'h00, PRESCALE_RESET});
    wr_reg(4'h2, 16'hFFFF);
    rd_chk("unmapped", 4'h2, 16'h0000);
    rd_chk("ctrl", REG_CTRL, 16'h0000);
    // halted write reads back
    wr_reg(REG_COUNT, 16'h1234);
    rd_chk("count_halted", REG_COUNT, 16'h1234);
    // timer mode, one tick per clock
    wr_reg(REG_COUNT, 16'h0003);
    wr_reg(REG_CTRL, 16'h0001);
    burst(16, 16'h0000, 16'h0003, COUNT_ALL_ONES, hit);
    check("timer_reload_read", {15'h0, hit}, 16'h0001);
    check("timer_irq", {15'h0, irq}, 16'h0001);
    // event counter down, then up
    wr_reg(REG_CTRL, 16'h0002);
    wr_reg(REG_COUNT, 16'h0002);
    wr_reg(REG_CTRL, 16'h0003);
    toggle_en <= 1'b1;
    burst(20, 16'h0000, 16'h0002, COUNT_ALL_ONES, hit);
    check("event_down_reload", {15'h0, hit}, 16'h0001);
    wr_reg(REG_CTRL, 16'h000A);
    wr_reg(REG_COUNT, 16'hFFFD);
    wr_reg(REG_CTRL, 16'h000B);
    burst(20, 16'hFFFD, 16'hFFFF, COUNT_ZERO, hit);
    check("event_up_reload", {15'h0, hit}, 16'h0001);
    // free-running up count on falling edges wraps through zero without reload
    wr_reg(REG_CTRL, 16'h005A);
    wr_reg(REG_COUNT, 16'hFFFE);
    wr_reg(REG_CTRL, 16'h005B);
    repeat (12) @(posedge core_clk_i);
    wr_reg(REG_CTRL, 16'h005A);
    burst(2, 16'h0001, 16'h0008, 16'h0001, hit);
    toggle_en <= 1'b0;
    // every mode change that sets the request flag
    for (int s = 0; s < 2; s++) begin
      for (int t = 2; t < 4; t++) begin
        wr_reg(REG_CTRL, 16'(s << 1));
        wr_reg(REG_IRQ, 16'h0000);
        wr_reg(REG_CTRL, 16'(t << 1));
        settle();
        check("mode_change_irq", {15'h0, irq}, 16'h0001);
      end
    end
    // one-shot stopped in mid-count
    wr_reg(REG_CTRL, 16'h0000);
    wr_reg(REG_PRESCALE, 16'h000F);
    wr_reg(REG_COUNT, 16'h0040);
    wr_reg(REG_CTRL, 16'h0025);
    settle();
    check("oneshot_entry_irq", {15'h0, irq}, 16'h0001);
    check("oneshot_no_trigger", {15'h0, pulse_pin}, 16'h0000);
    wr_reg(REG_IRQ, 16'h0000);
    toggle_en <= 1'b1;
    wait_pin(1'b1, 40);
    toggle_en <= 1'b0;
    // let a few ticks pass so that the reload on stop is visible
    repeat (40) @(posedge core_clk_i);
    wr_reg(REG_CTRL, 16'h0024);
    settle();
    check("oneshot_stop_pin", {15'h0, pulse_pin}, 16'h0000);
    check("oneshot_stop_irq", {15'h0, irq}, 16'h0001);
    rd_chk("oneshot_stop_count", REG_COUNT, 16'h0040);
    repeat (40) @(posedge core_clk_i);
    rd_chk("oneshot_halted", REG_COUNT, 16'h0040);
    // pwm stopped while low, then while high
    wr_reg(REG_CTRL, 16'h0000);
    wr_reg(REG_PRESCALE, 16'h0000);
    wr_reg(REG_COUNT, 16'h0010);
    wr_reg(REG_CTRL, 16'h0007);
    settle();
    check("pwm_entry_irq", {15'h0, irq}, 16'h0001);
    wr_reg(REG_IRQ, 16'h0000);
    wait_pin(1'b1, 20);
    rd_chk("irq_reg_pin", REG_IRQ, 16'h0002);
    wait_pin(1'b0, 40);
    settle();
    check("pwm_underflow_irq", {15'h0, irq}, 16'h0001);
    wr_reg(REG_IRQ, 16'h0000);
    wr_reg(REG_CTRL, 16'h0006);
    settle();
    check("pwm_stop_low_pin", {15'h0, pulse_pin}, 16'h0000);
    check("pwm_stop_low_irq", {15'h0, irq}, 16'h0000);
    wr_reg(REG_CTRL, 16'h0007);
    wait_pin(1'b1, 20);
    wr_reg(REG_CTRL, 16'h0006);
    settle();
    check("pwm_stop_high_pin", {15'h0, pulse_pin}, 16'h0000);
    rd_chk("pwm_stop_high_irq", REG_IRQ, 16'h0001);
    report_and_stop();
  end
endmodule : tb_multimode_timer_counter
